/* File: verilog/sll_pkg.sv */
// Purpose: Shared constants and types for the link layer control and status bank.
// Assumes: A 25 MHz device clock and byte addresses on the network side.
// Notes: Each register occupies one aligned 32-bit word.
package sll_pkg;
   // Register byte offsets.
   localparam logic [15:0] OFS_CTRL = 16'h0100;
   localparam logic [15:0] OFS_RWOFS = 16'h0108;
   localparam logic [15:0] OFS_STAT = 16'h0110;
   // Control word: writable bits and reset value (FIFO size code 7).
   localparam logic [31:0] CTRL_WMASK = 32'h014f_ff00;
   localparam logic [31:0] CTRL_RESET = 32'h0007_0000;
   // Control field positions.
   localparam int POS_LOOP = 8;
   localparam int POS_FIFO = 16;
   localparam int POS_JIT = 19;
   localparam int POS_RLD = 22;
   localparam int POS_ALIAS = 24;
   // FIFO size codes at or below this value cut receive delay.
   localparam logic [2:0] FIFO_REDUCE_MAX = 3'h3;
   // Status field positions.
   localparam int ST_LOAD = 0;
   localparam int ST_WD = 1;
   localparam int ST_ENH = 2;
   localparam int ST_LINK = 4;
   localparam int ST_LOOP = 8;
   // Loop modes per port.
   localparam logic [1:0] LOOP_AUTO = 2'h0;
   localparam logic [1:0] LOOP_ACLOSE = 2'h1;
   localparam logic [1:0] LOOP_OPEN = 2'h2;
   localparam logic [1:0] LOOP_CLOSED = 2'h3;
   // Remote link-down signalling times and their cycle counts.
   localparam int CLK_NS = 40;
   localparam int RLD_LONG_MS = 660;
   localparam int RLD_SHORT_US = 80;
   localparam int RLD_LONG_CYC = RLD_LONG_MS * 1000000 / CLK_NS;
   localparam int RLD_SHORT_CYC = RLD_SHORT_US * 1000 / CLK_NS;
   localparam int RLD_CW = 24;
   localparam int NPORT = 4;
   // Remote link-down signalling state.
   typedef enum logic [0:0] {RLD_IDLE = 1'b0, RLD_SIGNAL = 1'b1} sll_rld_e;
endpackage : sll_pkg

/* File: verilog/sll_loop_if.sv */
// Purpose: Carries loop configuration and port state between bank and loop logic.
// Assumes: All signals are on the device clock.
// Notes: wr is a one-cycle pulse per port on a control write.
`timescale 1ns/100ps
interface sll_loop_if;
   logic [3:0] link;
   logic [3:0] busy;
   logic [3:0] frame_ok;
   logic [3:0] wr;
   logic [7:0] cfg;
   logic [3:0] closed;
   modport ctrl (output link, busy, frame_ok, wr, cfg, input closed);
   modport port (input link, busy, frame_ok, wr, cfg, output closed);
endinterface : sll_loop_if

/* File: verilog/sll_loop.sv */
// Purpose: Per-port loop open/closed control from mode, link and frame activity.
// Assumes: Link is already synchronised; busy is high while a frame passes.
// Notes: Loop state and mode changes wait for the port to go idle.
`timescale 1ns/100ps
module sll_loop
   import sll_pkg::*;
(
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Bank side.
   sll_loop_if.port lp
);
   logic [3:0][1:0] mode, next_mode, pmode, next_pmode;
   logic [3:0] pend, next_pend, acl, next_acl, closed, next_closed;

   // Compute pending mode, active mode, auto-close latch and loop state.
   always_comb
   begin
      logic [1:0] f;
      logic [1:0] m;
      logic tgt;
      f = 2'h0;
      m = 2'h0;
      tgt = 1'b0;
      next_mode = mode;
      next_pmode = pmode;
      next_pend = pend;
      next_acl = acl;
      next_closed = closed;
      for (int i = 0; i < NPORT; i++)
      begin
         f = lp.cfg[2*i +: 2];
         if (lp.wr[i])
         begin
            next_pend[i] = 1'b1;
            next_pmode[i] = f;
         end
         m = mode[i];
         if (pend[i] && !lp.busy[i]) // [RQ6]
         begin
            m = pmode[i];
            next_mode[i] = pmode[i];
            next_pend[i] = lp.wr[i];
            if (pmode[i] == LOOP_ACLOSE && lp.link[i])
               next_acl[i] = 1'b0;
         end
         if (!lp.link[i])
            next_acl[i] = 1'b1;
         else if (lp.frame_ok[i])
            next_acl[i] = 1'b0;
         unique case (m)
            LOOP_AUTO: tgt = !lp.link[i]; // [RQ14]
            LOOP_ACLOSE: tgt = acl[i];
            LOOP_OPEN: tgt = 1'b0;
            LOOP_CLOSED: tgt = 1'b1;
         endcase
         if (!lp.busy[i]) // [RQ6]
            next_closed[i] = tgt;
      end
   end

   // Register loop state.
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         mode <= '0;
         pmode <= '0;
         pend <= '0;
         acl <= 4'hf;
         closed <= 4'hf;
      end
      else
      begin
         mode <= next_mode;
         pmode <= next_pmode;
         pend <= next_pend;
         acl <= next_acl;
         closed <= next_closed;
      end
   end

   assign lp.closed = closed;

   // Loop state never moves while a frame passes.
   AST_LOOP_HOLD: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RQ6]
      (|lp.busy) |=> (((closed ^ $past(closed)) & $past(lp.busy)) == 4'h0))
      else $error("Loop state changed during a frame.");

   // Auto mode closes port 1 when it is idle and its link is down.
   AST_AUTO_CLOSE: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RQ14]
      (mode[1] == LOOP_AUTO && !pend[1] && !lp.link[1] && !lp.busy[1]) |=> closed[1])
      else $error("Auto loop did not close on link down.");
endmodule : sll_loop

/* File: verilog/sll_bank.sv */
// Purpose: Link layer control, read/write offset and link status registers.
// Assumes: Network side writes and reads; local side only reads.
// Notes: Read data appears one cycle after the read strobe.
// Behaviour
// RQ1: The FIFO size code sets the half-full level that must be reached before forwarding, codes 0-3 cut delay and 7 is the default.
// RQ2: FIFO size and link detection from the configuration memory are taken only on the first load after reset.
// RQ3: Control bit 19 selects reduced backplane jitter and resets to normal.
// RQ4: Control bit 22 picks 660 ms or 80 us remote link-down signalling and resets to the long time.
// RQ5: With bit 24 set the alias address is accepted for configured-address commands, otherwise ignored.
// RQ6: A port's loop change waits until its current frame has ended.
// RQ7: Read-write commands read at the command address and write at that address plus the offset.
// RQ8: Status bit 0 is 1 only when the configuration loaded and the local interface is ready, else no memory access.
// RQ9: Status bit 2 shows enhanced link detection on at least one port.
// RQ10: Status bits 4-7 show the physical link of ports 0-3.
// RQ11: Status bits 9, 11, 13 and 15 show stable communication of ports 0-3.
// RQ12: Status bits 8, 10, 12 and 14 show each port's loop, 1 meaning closed.
// RQ13: A network read of the status register clears its network event request.
// RQ14: Auto loop mode closes a port at link down and opens it at link up.
// RQ15: Control and offset are written only from the network side; status is read-only.
// RQ16: Reserved control bits read zero and ignore writes.
`timescale 1ns/100ps
module sll_bank
   import sll_pkg::*;
#(
   parameter int RLD_LONG = RLD_LONG_CYC
)
(
   // Clock and reset.
   input wire logic clk_i,
   input wire logic reset_n_i,
   // Network side register access.
   input wire logic [15:0] net_addr_i,
   input wire logic net_wr_i,
   input wire logic net_rd_i,
   input wire logic [31:0] net_wdata_i,
   output logic [31:0] net_rdata_o,
   output logic net_event_clr_o,
   // Local process interface register access.
   input wire logic [15:0] loc_addr_i,
   input wire logic loc_rd_i,
   input wire logic loc_wr_i,
   output logic [31:0] loc_rdata_o,
   // Configuration load and health.
   input wire logic cfg_load_i,
   input wire logic cfg_load_ok_i,
   input wire logic [2:0] cfg_fifo_size_i,
   input wire logic cfg_enh_link_i,
   input wire logic local_ready_i,
   input wire logic wd_ok_i,
   output logic pd_mem_access_en_o,
   // Port state.
   input wire logic [3:0] link_pin_i,
   input wire logic [3:0] comm_i,
   input wire logic [3:0] frame_busy_i,
   input wire logic [3:0] frame_ok_i,
   output logic [3:0] loop_closed_o,
   // Receive FIFO.
   input wire logic [3:0] rx_fifo_level_i,
   output logic [2:0] fifo_size_o,
   output logic rx_delay_reduce_o,
   output logic forward_start_o,
   // Backplane link.
   input wire logic rld_req_i,
   output logic low_jitter_o,
   output logic remote_link_down_o,
   // Command addressing.
   input wire logic [15:0] cmd_addr_i,
   input wire logic cmd_fixed_i,
   input wire logic [15:0] station_addr_i,
   input wire logic [15:0] alias_addr_i,
   output logic addr_match_o,
   output logic alias_en_o,
   output logic [15:0] rw_rd_addr_o,
   output logic [15:0] rw_wr_addr_o
);
   logic rst_q1, rst_n;
   logic [3:0] ls1, ls2, ls3, link, next_link;
   logic [31:0] ctrl, next_ctrl;
   logic [15:0] rwofs, next_rwofs;
   logic load_done, next_load_done, cfg_ok, next_cfg_ok, enh, next_enh;
   logic [15:0] stat;
   logic [31:0] next_net_rdata, next_loc_rdata;
   logic next_evclr;
   sll_rld_e rld_st, next_rld_st;
   logic [RLD_CW-1:0] rld_cnt, next_rld_cnt;
   logic next_match, next_fwd;
   logic [15:0] next_rd_addr, next_wr_addr;
   sll_loop_if lp ();

   // Filtered pin level: follow the third stage once it agrees with the second.
   function automatic logic [3:0] pin_filter(input logic [3:0] cur, input logic [3:0] s2,
      input logic [3:0] s3);
      pin_filter = (s2 & s3) | (cur & (s2 ^ s3));
   endfunction : pin_filter

   // Register read decode shared by both access sides.
   function automatic logic [31:0] reg_read(input logic [15:0] a, input logic [31:0] c,
      input logic [15:0] o, input logic [15:0] s);
      if (a == OFS_CTRL)
         reg_read = c;
      else if (a == OFS_RWOFS)
         reg_read = {16'h0000, o};
      else if (a == OFS_STAT)
         reg_read = {16'h0000, s};
      else
         reg_read = 32'h0000_0000;
   endfunction : reg_read

   // Reset release through two flip-flops.
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         rst_q1 <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         rst_q1 <= 1'b1;
         rst_n <= rst_q1;
      end
   end

   // Three-stage synchroniser for the link pins.
   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ls1 <= '0;
         ls2 <= '0;
         ls3 <= '0;
      end
      else
      begin
         ls1 <= link_pin_i;
         ls2 <= ls1;
         ls3 <= ls2;
      end
   end

   // Next register contents; local writes never reach them.
   always_comb
   begin
      next_link = pin_filter(link, ls2, ls3);
      next_ctrl = ctrl;
      next_rwofs = rwofs;
      next_load_done = load_done;
      next_cfg_ok = cfg_ok;
      next_enh = enh;
      if (net_wr_i && net_addr_i == OFS_CTRL) // [RQ15]
         next_ctrl = (net_wdata_i & CTRL_WMASK) | (ctrl & ~CTRL_WMASK); // [RQ16]
      if (net_wr_i && net_addr_i == OFS_RWOFS) // [RQ15]
         next_rwofs = net_wdata_i[15:0];
      if (cfg_load_i)
      begin
         next_cfg_ok = cfg_load_ok_i;
         next_load_done = 1'b1;
         if (!load_done) // [RQ2]
         begin
            next_ctrl[POS_FIFO +: 3] = cfg_fifo_size_i;
            next_enh = cfg_enh_link_i;
         end
      end
   end

   // Register the bank.
   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         link <= '0;
         ctrl <= CTRL_RESET; // [RQ1] [RQ3] [RQ4]
         rwofs <= '0;
         load_done <= 1'b0;
         cfg_ok <= 1'b0;
         enh <= 1'b0;
      end
      else
      begin
         link <= next_link;
         ctrl <= next_ctrl;
         rwofs <= next_rwofs;
         load_done <= next_load_done;
         cfg_ok <= next_cfg_ok;
         enh <= next_enh;
      end
   end

   // Status word assembly.
   always_comb
   begin
      stat = '0;
      stat[ST_LOAD] = cfg_ok && local_ready_i; // [RQ8]
      stat[ST_WD] = wd_ok_i;
      stat[ST_ENH] = enh; // [RQ9]
      stat[ST_LINK +: 4] = link; // [RQ10]
      for (int i = 0; i < NPORT; i++)
      begin
         stat[ST_LOOP + 2*i] = lp.closed[i]; // [RQ12]
         stat[ST_LOOP + 2*i + 1] = comm_i[i]; // [RQ11]
      end
   end

   // Loop logic hookup; every control write rearms the loop fields.
   // The loop fields come from the next control value, so the write pulse carries new modes.
   assign lp.link = link;
   assign lp.busy = frame_busy_i;
   assign lp.frame_ok = frame_ok_i;
   assign lp.cfg = next_ctrl[POS_LOOP +: 8];
   assign lp.wr = {4{net_wr_i && net_addr_i == OFS_CTRL}};

   sll_loop u_loop (
      .clk_i(clk_i),
      .rst_n_i(rst_n),
      .lp(lp)
   );

   // Read data, event clear and command address results.
   always_comb
   begin
      next_net_rdata = net_rd_i ? reg_read(net_addr_i, ctrl, rwofs, stat) : net_rdata_o;
      next_loc_rdata = loc_rd_i ? reg_read(loc_addr_i, ctrl, rwofs, stat) : loc_rdata_o;
      next_evclr = net_rd_i && net_addr_i == OFS_STAT; // [RQ13]
      next_match = (cmd_addr_i == station_addr_i) ||
         (cmd_fixed_i && ctrl[POS_ALIAS] && cmd_addr_i == alias_addr_i); // [RQ5]
      next_rd_addr = cmd_addr_i; // [RQ7]
      next_wr_addr = cmd_addr_i + rwofs; // [RQ7]
      next_fwd = {1'b0, rx_fifo_level_i} >= ({2'b00, ctrl[POS_FIFO +: 3]} + 5'h01); // [RQ1]
   end

   // Register read data and command results.
   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         net_rdata_o <= '0;
         loc_rdata_o <= '0;
         net_event_clr_o <= 1'b0;
         addr_match_o <= 1'b0;
         rw_rd_addr_o <= '0;
         rw_wr_addr_o <= '0;
         forward_start_o <= 1'b0;
      end
      else
      begin
         net_rdata_o <= next_net_rdata;
         loc_rdata_o <= next_loc_rdata;
         net_event_clr_o <= next_evclr;
         addr_match_o <= next_match;
         rw_rd_addr_o <= next_rd_addr;
         rw_wr_addr_o <= next_wr_addr[15:0];
         forward_start_o <= next_fwd;
      end
   end

   // Remote link-down signalling timer.
   always_comb
   begin
      next_rld_st = rld_st;
      next_rld_cnt = rld_cnt;
      unique case (rld_st)
         RLD_IDLE:
            if (rld_req_i)
            begin
               next_rld_st = RLD_SIGNAL;
               next_rld_cnt = ctrl[POS_RLD] ? RLD_CW'(RLD_SHORT_CYC - 1) : // [RQ4]
                  RLD_CW'(RLD_LONG - 1);
            end
         RLD_SIGNAL:
            if (rld_cnt == '0)
               next_rld_st = RLD_IDLE;
            else
               next_rld_cnt = rld_cnt - 1'b1;
      endcase
   end

   // Register the timer.
   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rld_st <= RLD_IDLE;
         rld_cnt <= '0;
      end
      else
      begin
         rld_st <= next_rld_st;
         rld_cnt <= next_rld_cnt;
      end
   end

   // Control outputs.
   assign remote_link_down_o = rld_st == RLD_SIGNAL;
   assign fifo_size_o = ctrl[POS_FIFO +: 3];
   assign rx_delay_reduce_o = ctrl[POS_FIFO +: 3] <= FIFO_REDUCE_MAX; // [RQ1]
   assign low_jitter_o = ctrl[POS_JIT]; // [RQ3]
   assign alias_en_o = ctrl[POS_ALIAS]; // [RQ5]
   assign pd_mem_access_en_o = stat[ST_LOAD]; // [RQ8]
   assign loop_closed_o = lp.closed;

   AST_NO_PD_ACCESS: assert property (@(posedge clk_i) disable iff (!rst_n) // [RQ8]
      !cfg_ok |-> !pd_mem_access_en_o)
      else $error("Process memory access without a good load.");

   AST_EVENT_CLEAR: assert property (@(posedge clk_i) disable iff (!rst_n) // [RQ13]
      (net_rd_i && net_addr_i == OFS_STAT) |=> net_event_clr_o)
      else $error("Status read did not clear the event request.");

   // Only a network read of the status word may clear the event request.
   AST_EVENT_ONLY: assert property (@(posedge clk_i) disable iff (!rst_n) // [RQ13]
      !(net_rd_i && net_addr_i == OFS_STAT) |=> !net_event_clr_o)
      else $error("Event request cleared without a status read.");

   AST_RW_OFFSET: assert property (@(posedge clk_i) disable iff (!rst_n) // [RQ7]
      $stable(rwofs) |=> rw_wr_addr_o == rw_rd_addr_o + $past(rwofs))
      else $error("Write address is not read address plus offset.");

   AST_FIRST_LOAD: assert property (@(posedge clk_i) disable iff (!rst_n) // [RQ2]
      (load_done && cfg_load_i && !net_wr_i) |=> $stable(fifo_size_o) && $stable(enh))
      else $error("A later load changed the first-load values.");

   AST_LOCAL_NO_WRITE: assert property (@(posedge clk_i) disable iff (!rst_n) // [RQ15]
      (loc_wr_i && !net_wr_i && !cfg_load_i) |=> $stable(ctrl) && $stable(rwofs))
      else $error("Local write changed a register.");

   // A short signalling request accepted while the timer is idle.
   sequence s_rld_short_start;
      rld_st == RLD_IDLE && rld_req_i && ctrl[POS_RLD];
   endsequence

   AST_RLD_SHORT: assert property (@(posedge clk_i) disable iff (!rst_n) // [RQ4]
      s_rld_short_start |=> remote_link_down_o [*8])
      else $error("Remote link-down signalling ended too soon.");

   AST_ALIAS_OFF: assert property (@(posedge clk_i) disable iff (!rst_n) // [RQ5]
      (!ctrl[POS_ALIAS] && cmd_addr_i != station_addr_i && $stable(ctrl)) |=> !addr_match_o)
      else $error("Alias accepted while disabled.");

   AST_RESERVED_ZERO: assert property (@(posedge clk_i) disable iff (!rst_n) // [RQ16]
      (ctrl & ~CTRL_WMASK) == 32'h0000_0000)
      else $error("Reserved control bits are set.");
endmodule : sll_bank

/* File: sim/sll_port_model.sv */
// Purpose: Port traffic model on the far side of the four ports.
// Assumes: Runs on the device clock; start is sampled on rising edges.
// Notes: A port ignores a start while its frame is still passing.
`timescale 1ns/100ps
module sll_port_model
(
   // Clock.
   input wire logic clk_i,
   // Frame requests and frame length in cycles.
   input wire logic [3:0] start_i,
   input wire logic [7:0] len_i,
   // Port activity seen by the bank.
   output logic [3:0] busy_o,
   output logic [3:0] ok_o
);
   logic [7:0] cnt [4] = '{default: 8'h00};
   // Count down the cycles left of each frame.
   always @(posedge clk_i)
   begin
      for (int p = 0; p < 4; p++)
      begin
         if (start_i[p] && cnt[p] == 8'h00)
            cnt[p] <= len_i;
         else if (cnt[p] != 8'h00)
            cnt[p] <= cnt[p] - 8'h01;
      end
   end
   // Busy while cycles remain; the last cycle marks a valid frame.
   always_comb
   begin
      for (int p = 0; p < 4; p++)
      begin
         busy_o[p] = cnt[p] != 8'h00;
         ok_o[p] = cnt[p] == 8'h01;
      end
   end
endmodule : sll_port_model

/* File: sim/tb_top.sv */
// Purpose: Self-checking bench for the link control and status bank.
// Assumes: Inputs change at rising edges; checks run 1 ns after an edge.
// Notes: The long link-down time is cut to 50 cycles.
`timescale 1ns/100ps
module tb_top
   import sll_pkg::*;
;
   localparam int RLDL = 50;
   int n_mismatch = 0;
   int comparisons = 0;
   logic [31:0] d, w;
   logic ev;
   // Design inputs.
   logic clk_i = 0, reset_n_i = 0, net_wr_i = 0, net_rd_i = 0, loc_rd_i = 0;
   logic loc_wr_i = 0, cfg_load_i = 0, cfg_load_ok_i = 0, cfg_enh_link_i = 0;
   logic local_ready_i = 0, wd_ok_i = 0, rld_req_i = 0, cmd_fixed_i = 0;
   logic [15:0] net_addr_i = '0, loc_addr_i = '0, cmd_addr_i = '0;
   logic [15:0] station_addr_i = 16'h1234, alias_addr_i = 16'h0abc;
   logic [31:0] net_wdata_i = '0;
   logic [2:0] cfg_fifo_size_i = '0;
   logic [3:0] link_pin_i = '0, comm_i = '0, rx_fifo_level_i = '0, fr_start = '0;
   logic [7:0] fr_len = 8'h10;
   // Design outputs.
   logic [31:0] net_rdata_o, loc_rdata_o;
   logic net_event_clr_o, pd_mem_access_en_o, rx_delay_reduce_o, forward_start_o;
   logic low_jitter_o, remote_link_down_o, addr_match_o, alias_en_o;
   logic [3:0] loop_closed_o, frame_busy_i, frame_ok_i;
   logic [2:0] fifo_size_o;
   logic [15:0] rw_rd_addr_o, rw_wr_addr_o;

   // Device clock.
   initial
   begin
      forever #20 clk_i = ~clk_i;
   end

   sll_bank #(.RLD_LONG(RLDL)) i_sll_bank (.clk_i, .reset_n_i, .net_addr_i, .net_wr_i,
      .net_rd_i, .net_wdata_i, .net_rdata_o, .net_event_clr_o, .loc_addr_i, .loc_rd_i,
      .loc_wr_i, .loc_rdata_o, .cfg_load_i, .cfg_load_ok_i, .cfg_fifo_size_i,
      .cfg_enh_link_i, .local_ready_i, .wd_ok_i, .pd_mem_access_en_o, .link_pin_i,
      .comm_i, .frame_busy_i, .frame_ok_i, .loop_closed_o, .rx_fifo_level_i,
      .fifo_size_o, .rx_delay_reduce_o, .forward_start_o, .rld_req_i, .low_jitter_o,
      .remote_link_down_o, .cmd_addr_i, .cmd_fixed_i, .station_addr_i, .alias_addr_i,
      .addr_match_o, .alias_en_o, .rw_rd_addr_o, .rw_wr_addr_o);

   sll_port_model i_sll_port_model (.clk_i, .start_i(fr_start), .len_i(fr_len),
      .busy_o(frame_busy_i), .ok_o(frame_ok_i));

   // Compare, count and report.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic final_report();
      if (n_mismatch == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : final_report

   // A wait that ran out of its bound ends the run.
   task automatic guard(input int k, input int lim);
      if (k >= lim)
      begin
         n_mismatch++;
         final_report();
      end
   endtask : guard

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask : cyc

   // Register write from the network side, or from the local side.
   task automatic wr(input logic [15:0] a, input logic [31:0] v, input logic net = 1'b1);
      @(posedge clk_i);
      net_addr_i <= a;
      loc_addr_i <= a;
      net_wdata_i <= v;
      net_wr_i <= net;
      loc_wr_i <= !net;
      @(posedge clk_i);
      net_wr_i <= 1'b0;
      loc_wr_i <= 1'b0;
   endtask : wr

   // Register read; data and the event clear are taken a cycle later.
   task automatic rd(input logic [15:0] a, input logic net = 1'b1);
      @(posedge clk_i);
      net_addr_i <= a;
      loc_addr_i <= a;
      net_rd_i <= net;
      loc_rd_i <= !net;
      @(posedge clk_i);
      net_rd_i <= 1'b0;
      loc_rd_i <= 1'b0;
      #1;
      d = net ? net_rdata_o : loc_rdata_o;
      ev = net_event_clr_o;
   endtask : rd

   task automatic load(input logic [2:0] fs, input logic en);
      @(posedge clk_i);
      cfg_load_i <= 1'b1;
      cfg_load_ok_i <= 1'b1;
      cfg_fifo_size_i <= fs;
      cfg_enh_link_i <= en;
      local_ready_i <= 1'b1;
      @(posedge clk_i);
      cfg_load_i <= 1'b0;
      #1;
   endtask : load

   task automatic frame(input logic [3:0] p, input logic [7:0] n);
      @(posedge clk_i);
      fr_start <= p;
      fr_len <= n;
      @(posedge clk_i);
      fr_start <= 4'h0;
   endtask : frame

   // Wait until no port carries a frame.
   task automatic idle();
      int k;
      #1;
      for (k = 0; k < 200 && frame_busy_i !== 4'h0; k++)
         cyc(1);
      guard(k, 200);
      cyc(3);
   endtask : idle

   // Count the cycles of remote link-down signalling.
   task automatic rld(input int exp_n);
      int n;
      @(posedge clk_i);
      rld_req_i <= 1'b1;
      @(posedge clk_i);
      rld_req_i <= 1'b0;
      #1;
      for (n = 0; n < 3000 && remote_link_down_o === 1'b1; n++)
         cyc(1);
      guard(n, 3000);
      chk(n, exp_n);
   endtask : rld

   // Expected status word in auto loop mode after a good load.
   function automatic logic [31:0] st_exp(input logic [3:0] lk, input logic [3:0] cm,
      input logic wd);
      logic [31:0] s;
      s = {24'h000000, lk, 2'b01, wd, 1'b1};
      for (int p = 0; p < 4; p++)
         s[8 + 2 * p +: 2] = {cm[p], ~lk[p]};
      return s;
   endfunction : st_exp

   // Main sequence.
   initial
   begin
      w = $urandom(32'hadb9);
      repeat (10) @(posedge clk_i);
      reset_n_i <= 1'b1;
      cyc(3);
      rd(OFS_CTRL);
      chk(d, CTRL_RESET);
      rd(OFS_STAT);
      chk({d[30:0], ev}, 32'h0000_aa01);
      load(3'h3, 1'b1);
      chk(32'({fifo_size_o, pd_mem_access_en_o}), 32'h7);
      @(posedge clk_i);
      local_ready_i <= 1'b0;
      cyc(3);
      chk(32'(pd_mem_access_en_o), 32'h0);
      load(3'h5, 1'b0);
      rd(OFS_STAT);
      chk(32'({fifo_size_o, d[2:0]}), 32'h1d);
      // Control word: every FIFO code, random reserved bits, local writes.
      for (int i = 0; i < 8; i++)
      begin
         w = $urandom;
         w[18:8] = {3'(i), 8'h00};
         wr(OFS_CTRL, w);
         wr(OFS_CTRL, ~w, 1'b0);
         rd(OFS_CTRL, 1'b0);
         chk(d, w & CTRL_WMASK);
         chk(32'({fifo_size_o, rx_delay_reduce_o, low_jitter_o, alias_en_o}),
            32'({w[18:16], i < 4, w[19], w[24]}));
         @(posedge clk_i);
         rx_fifo_level_i <= 4'(i);
         cyc(2);
         chk(32'(forward_start_o), 32'h0);
         @(posedge clk_i);
         rx_fifo_level_i <= 4'(i + 1);
         cyc(2);
         chk(32'(forward_start_o), 32'h1);
      end
      rd(16'h0104);
      chk(d, 32'h0);
      // Read-write offset, with address wrap first.
      for (int i = 0; i < 6; i++)
      begin
         w = (i == 0) ? 32'h0000_0002 : $urandom;
         wr(OFS_RWOFS, w);
         rd(OFS_RWOFS);
         chk(d, {16'h0000, w[15:0]});
         @(posedge clk_i);
         cmd_addr_i <= (i == 0) ? 16'hffff : 16'($urandom);
         cyc(2);
         chk({rw_rd_addr_o, rw_wr_addr_o}, {cmd_addr_i, cmd_addr_i + w[15:0]});
      end
      // Alias acceptance for each enable and command kind.
      for (int i = 0; i < 5; i++)
      begin
         wr(OFS_CTRL, {7'h00, i[0], 24'h070000});
         @(posedge clk_i);
         cmd_fixed_i <= i[1];
         cmd_addr_i <= (i == 4) ? station_addr_i : alias_addr_i;
         cyc(2);
         chk(32'(addr_match_o), 32'((i[0] & i[1]) | i[2]));
      end
      // Link, communication and loop status; status writes are dropped.
      for (int i = 0; i < 8; i++)
      begin
         w = (i == 0) ? 32'h0 : (i == 1) ? 32'h33 : $urandom;
         @(posedge clk_i);
         link_pin_i <= w[3:0];
         comm_i <= w[7:4];
         wd_ok_i <= w[8];
         cyc(8);
         wr(OFS_STAT, ~w);
         rd(OFS_STAT);
         chk(d, st_exp(w[3:0], w[7:4], w[8]));
         chk(32'({ev, loop_closed_o}), 32'({1'b1, ~w[3:0]}));
         rd(OFS_STAT, 1'b0);
         chk(32'(ev), 32'h0);
      end
      wr(OFS_CTRL, CTRL_RESET);
      rld(RLDL);
      wr(OFS_CTRL, CTRL_RESET | 32'h0040_0000);
      rld(RLD_SHORT_CYC);
      // Loop modes auto, auto-close, open, closed on ports 0 to 3.
      @(posedge clk_i);
      link_pin_i <= 4'h0;
      wr(OFS_CTRL, 32'h0007_e400);
      cyc(8);
      chk(32'(loop_closed_o), 32'hb);
      @(posedge clk_i);
      link_pin_i <= 4'hf;
      cyc(8);
      chk(32'(loop_closed_o), 32'ha);
      frame(4'h2, 8'h05);
      idle();
      chk(32'(loop_closed_o), 32'h8);
      frame(4'h4, 8'h28);
      wr(OFS_CTRL, 32'h0007_f400);
      cyc(10);
      chk(32'(loop_closed_o), 32'h8);
      idle();
      chk(32'(loop_closed_o), 32'hc);
      final_report();
   end
endmodule : tb_top
